// ==== inc/pic_pkg.sv ====
/*
  pic_pkg: register offsets, field positions, reset values, vector table
  constants and carrier types of the priority interrupt controller.
  Assumes a 32-bit APB slave with an 8-bit byte address.
*/
package pic_pkg;
  // byte offsets of the register words
  localparam logic [7:0]   OFF_CTRL1   = 8'h00;
  localparam logic [7:0]   OFF_CTRL2   = 8'h04;
  localparam logic [7:0]   OFF_PEND    = 8'h08;
  localparam logic [7:0]   OFF_STAT    = 8'h0c;
  localparam logic [7:0]   OFF_CORE    = 8'h10;
  localparam logic [7:0]   OFF_FLAG0   = 8'h20;
  localparam logic [7:0]   OFF_EN0     = 8'h30;
  localparam logic [7:0]   OFF_PRIO0   = 8'h40;
  localparam int           N_BIT_WORDS = 4;
  localparam int           N_PRIO_WORDS = 11;
  localparam int           N_PRIO_SRC  = 88;
  // request numbers that exist; all others are reserved and never raised
  localparam logic [127:0] IMPL_MASK   = 128'h00000000_00002003_c2000020_201f3fef;
  // request numbers fed by the three external pins
  localparam int           EXT_SRC0    = 0;
  localparam int           EXT_SRC1    = 20;
  localparam int           EXT_SRC2    = 29;
  // first global control word
  localparam int           NEST_BIT    = 15;
  localparam int           OSC_BIT     = 1;
  localparam int           STK_BIT     = 2;
  localparam int           ADDR_BIT    = 3;
  localparam int           MATH_BIT    = 4;
  localparam logic [15:0]  CTRL1_MASK  = 16'hffde;
  // second global control word
  localparam int           ALT_BIT     = 15;
  localparam logic [15:0]  CTRL2_MASK  = 16'h8007;
  // level bits in status word, core control word and pending word
  localparam int           IPL_LSB     = 5;
  localparam int           CPU_LEVEL_BIT_THREE_BIT    = 3;
  localparam int           ILR_LSB     = 8;
  // vector table
  localparam logic [23:0]  VEC_BASE    = 24'h000004;
  localparam logic [23:0]  ALT_OFS     = 24'h000100;
  localparam logic [6:0]   USER_VEC0   = 7'h08;
  localparam logic [6:0]   TV_OSC      = 7'h01;
  localparam logic [6:0]   TV_ADDR     = 7'h02;
  localparam logic [6:0]   TV_STK      = 7'h03;
  localparam logic [6:0]   TV_MATH     = 7'h04;
  // reset values
  localparam logic [15:0]  RST_CTRL    = 16'h0000;
  localparam logic [2:0]   RST_LVL     = 3'h0;

  typedef struct packed {
    logic [3:0] lvl;
    logic [6:0] vec;
  } pic_pend_s;

  // program address of a vector; user vector n+8 lands on 0x14 + 2n
  function automatic logic [23:0] pic_vec_addr(input logic [6:0] v, input logic alt);
    pic_vec_addr = VEC_BASE + (alt ? ALT_OFS : 24'h000000) + {16'h0000, v, 1'b0};
  endfunction : pic_vec_addr
endpackage : pic_pkg

// ==== logic/pic_top.sv ====
/*
  pic_top: priority interrupt controller with APB register access.
  Holds request flags, enables, priority fields, global controls, the cpu
  priority level and the pending-vector latch; merges requests into one.
  Assumes peripheral requests and trap events are pclk-synchronous pulses,
  external pins are asynchronous, and the core loads its level on entry.
*/
`timescale 1ns/1ns
module pic_top #(
  parameter int N_SRC = 118
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [N_SRC-1:0]  src_pulse,
  input  wire logic [2:0]        ext_pin,
  input  wire logic [3:0]        trap_evt,
  input  wire logic              level_ld,
  input  wire logic [3:0]        level_in,
  output logic                   irq_req,
  output pic_pkg::pic_pend_s     pend,
  output logic      [23:0]       irq_addr,
  output logic                   trap_req,
  output logic      [23:0]       trap_addr,
  output logic      [3:0]        cpu_level
);
  import pic_pkg::*;

  if (N_SRC > 128 || N_SRC < 78) begin : g_chk
    $error("pic_top: N_SRC must lie between 78 and 128");
  end

  logic [15:0]  ctrl1_q, ctrl1_d;
  logic [15:0]  ctrl2_q, ctrl2_d;
  logic [127:0] flag_q, flag_d;
  logic [127:0] en_q, en_d;
  logic [2:0]   prio_q [N_PRIO_SRC];
  logic [2:0]   prio_d [N_PRIO_SRC];
  logic [2:0]   ipl_q, ipl_d;
  logic         cpu_level_bit_three_q, cpu_level_bit_three_d;
  logic [31:0]  prdata_q, prdata_d;
  logic         err_q, err_d;
  logic [2:0]   s1_q, s2_q, s3_q;
  logic [2:0]   ext_edge;
  logic [127:0] set_vec;
  logic [3:0]   cur_lvl;
  logic         map_ok;
  logic [31:0]  rd_word;
  logic         wr_en;
  logic [7:0]   fofs;
  logic [7:0]   eofs;
  logic [7:0]   pofs;
  pic_pend_s    pend_q, pend_d;
  logic         irq_q, irq_d;
  logic [23:0]  iaddr_q, iaddr_d;
  logic         trap_q, trap_d;
  logic [23:0]  taddr_q, taddr_d;
  logic [2:0]   best_lvl;
  logic [6:0]   best_idx;
  logic         found;

  //////////////////////////////////////////////////////////////////////////
  // external pins: two-stage sync, third stage only for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
    end else begin
      s1_q <= ext_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // polarity select per pin: set picks falling edge
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      ext_edge[k] = ctrl2_q[k] ? (s3_q[k] & ~s2_q[k]) : (s2_q[k] & ~s3_q[k]);
    end
  end

  // hardware set sources, reserved numbers masked off
  always_comb begin
    set_vec = 128'(src_pulse);
    set_vec[EXT_SRC0] = set_vec[EXT_SRC0] | ext_edge[0];
    set_vec[EXT_SRC1] = set_vec[EXT_SRC1] | ext_edge[1];
    set_vec[EXT_SRC2] = set_vec[EXT_SRC2] | ext_edge[2];
    set_vec = set_vec & IMPL_MASK;
  end

  //////////////////////////////////////////////////////////////////////////
  // address decode, shared by read mux and write path
  function automatic logic in_rng(input logic [7:0] a, input logic [7:0] base,
                                  input int words);
    in_rng = (a >= base) && ({1'b0, a} < ({1'b0, base} + 9'(words * 4)));
  endfunction : in_rng

  assign fofs = paddr - OFF_FLAG0;
  assign eofs = paddr - OFF_EN0;
  assign pofs = paddr - OFF_PRIO0;
  assign cur_lvl = {cpu_level_bit_three_q, ipl_q};

  // read mux; unimplemented bits read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    map_ok  = (paddr[1:0] == 2'h0);
    if (paddr == OFF_CTRL1) begin
      rd_word[15:0] = ctrl1_q;
    end else if (paddr == OFF_CTRL2) begin
      rd_word[15:0] = ctrl2_q;
    end else if (paddr == OFF_PEND) begin
      rd_word[ILR_LSB +: 4] = pend_q.lvl;
      rd_word[6:0] = pend_q.vec;
    end else if (paddr == OFF_STAT) begin
      rd_word[IPL_LSB +: 3] = ipl_q;
    end else if (paddr == OFF_CORE) begin
      rd_word[CPU_LEVEL_BIT_THREE_BIT] = cpu_level_bit_three_q;
    end else if (in_rng(paddr, OFF_FLAG0, N_BIT_WORDS)) begin
      rd_word = flag_q[fofs[3:2]*32 +: 32];
    end else if (in_rng(paddr, OFF_EN0, N_BIT_WORDS)) begin
      rd_word = en_q[eofs[3:2]*32 +: 32];
    end else if (in_rng(paddr, OFF_PRIO0, N_PRIO_WORDS)) begin
      for (int j = 0; j < 8; j++) begin
        rd_word[4*j +: 3] = prio_q[int'(pofs[5:2])*8 + j];
      end
    end else begin
      map_ok = 1'b0;
    end
  end

  // writes take effect in the access phase; zero wait states
  assign wr_en = psel & penable & pwrite & map_ok;

  // next state of the register file; hardware sets win over software writes
  always_comb begin
    ctrl1_d  = ctrl1_q;
    ctrl2_d  = ctrl2_q;
    flag_d   = flag_q;
    en_d     = en_q;
    prio_d   = prio_q;
    ipl_d    = ipl_q;
    cpu_level_bit_three_d   = cpu_level_bit_three_q;
    prdata_d = prdata_q;
    err_d    = err_q;
    if (psel & ~penable) begin
      prdata_d = pwrite ? 32'h0000_0000 : rd_word;
      err_d    = ~map_ok;
    end
    if (wr_en) begin
      if (paddr == OFF_CTRL1) begin
        ctrl1_d = pwdata[15:0] & CTRL1_MASK;
      end else if (paddr == OFF_CTRL2) begin
        ctrl2_d = pwdata[15:0] & CTRL2_MASK;
      end else if (paddr == OFF_STAT && !ctrl1_q[NEST_BIT]) begin
        ipl_d = pwdata[IPL_LSB +: 3];
      end else if (in_rng(paddr, OFF_FLAG0, N_BIT_WORDS)) begin
        flag_d[fofs[3:2]*32 +: 32] = pwdata;
      end else if (in_rng(paddr, OFF_EN0, N_BIT_WORDS)) begin
        en_d[eofs[3:2]*32 +: 32] = pwdata;
      end else if (in_rng(paddr, OFF_PRIO0, N_PRIO_WORDS)) begin
        for (int j = 0; j < 8; j++) begin
          prio_d[int'(pofs[5:2])*8 + j] = pwdata[4*j +: 3];
        end
      end
    end
    // core control word and bit three have no software write path
    if (level_ld) begin
      ipl_d  = level_in[2:0];
      cpu_level_bit_three_d = level_in[3];
    end
    flag_d = (flag_d & IMPL_MASK) | set_vec;
    en_d   = en_d & IMPL_MASK;
    ctrl1_d[OSC_BIT]  = ctrl1_d[OSC_BIT]  | trap_evt[0];
    ctrl1_d[ADDR_BIT] = ctrl1_d[ADDR_BIT] | trap_evt[1];
    ctrl1_d[STK_BIT]  = ctrl1_d[STK_BIT]  | trap_evt[2];
    ctrl1_d[MATH_BIT] = ctrl1_d[MATH_BIT] | trap_evt[3];
  end

  // register file, all cleared at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_q  <= RST_CTRL;
      ctrl2_q  <= RST_CTRL;
      flag_q   <= '0;
      en_q     <= '0;
      for (int i = 0; i < N_PRIO_SRC; i++) begin
        prio_q[i] <= RST_LVL;
      end
      ipl_q    <= RST_LVL;
      cpu_level_bit_three_q   <= 1'b0;
      prdata_q <= 32'h0000_0000;
      err_q    <= 1'b0;
    end else begin
      ctrl1_q  <= ctrl1_d;
      ctrl2_q  <= ctrl2_d;
      flag_q   <= flag_d;
      en_q     <= en_d;
      prio_q   <= prio_d;
      ipl_q    <= ipl_d;
      cpu_level_bit_three_q   <= cpu_level_bit_three_d;
      prdata_q <= prdata_d;
      err_q    <= err_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // arbitration: strict greater keeps the lowest number on a tie; a start
  // level of zero keeps priority 0 out; any level of 7 or more beats all
  always_comb begin
    best_lvl = 3'h0;
    best_idx = 7'h00;
    found    = 1'b0;
    for (int i = 0; i < N_PRIO_SRC; i++) begin
      if (flag_q[i] && en_q[i] && ({1'b0, prio_q[i]} > cur_lvl)
          && (prio_q[i] > best_lvl)) begin
        best_lvl = prio_q[i];
        best_idx = 7'(i);
        found    = 1'b1;
      end
    end
  end

  // pending latch and vector addresses
  always_comb begin
    pend_d  = pend_q;
    iaddr_d = iaddr_q;
    irq_d   = found;
    if (found) begin
      pend_d.vec = best_idx + USER_VEC0;
      pend_d.lvl = {1'b0, best_lvl};
      iaddr_d    = pic_vec_addr(best_idx + USER_VEC0, ctrl2_q[ALT_BIT]);
    end
    // trap order: oscillator, address, stack, math
    trap_d  = |{ctrl1_q[OSC_BIT], ctrl1_q[ADDR_BIT], ctrl1_q[STK_BIT], ctrl1_q[MATH_BIT]};
    taddr_d = taddr_q;
    if (ctrl1_q[OSC_BIT]) begin
      taddr_d = pic_vec_addr(TV_OSC, ctrl2_q[ALT_BIT]);
    end else if (ctrl1_q[ADDR_BIT]) begin
      taddr_d = pic_vec_addr(TV_ADDR, ctrl2_q[ALT_BIT]);
    end else if (ctrl1_q[STK_BIT]) begin
      taddr_d = pic_vec_addr(TV_STK, ctrl2_q[ALT_BIT]);
    end else if (ctrl1_q[MATH_BIT]) begin
      taddr_d = pic_vec_addr(TV_MATH, ctrl2_q[ALT_BIT]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q  <= '0;
      iaddr_q <= 24'h000000;
      irq_q   <= 1'b0;
      trap_q  <= 1'b0;
      taddr_q <= 24'h000000;
    end else begin
      pend_q  <= pend_d;
      iaddr_q <= iaddr_d;
      irq_q   <= irq_d;
      trap_q  <= trap_d;
      taddr_q <= taddr_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata    = prdata_q;
  assign pslverr   = err_q;
  assign pready    = 1'b1;      // never stalls the bus
  assign irq_req   = irq_q;
  assign pend      = pend_q;
  assign irq_addr  = iaddr_q;
  assign trap_req  = trap_q;
  assign trap_addr = taddr_q;
  assign cpu_level = {cpu_level_bit_three_q, ipl_q};
endmodule : pic_top

// ==== sim/pic_core_model.sv ====
/* pic_core_model: core that takes the merged request.
   Assumes pend and irq_req of pic_top on the same clock. */
`timescale 1ns/1ns
module pic_core_model (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              go,
  input wire logic [3:0]        dly,
  input wire logic              irq_req,
  input wire pic_pkg::pic_pend_s pend,
  output logic                  level_ld,
  output logic [3:0]            level_in,
  output int                    taken
);
  import pic_pkg::*;
  logic [3:0] cnt_q;
  // entry after dly cycles; level_in toggles on every cycle without an entry
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
      level_ld <= 1'b0;
      level_in <= 4'h0;
      taken <= 0;
    end else begin
      level_ld <= 1'b0;
      level_in <= ~level_in;
      if (go && irq_req && !level_ld) begin
        if (cnt_q == dly) begin
          level_ld <= 1'b1;
          level_in <= pend.lvl;
          taken <= taken + 1;
          cnt_q <= 4'h0;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end
endmodule : pic_core_model

// ==== sim/pic_props.sv ====
/* pic_props: port checker for pic_top.
   Assumes bind into pic_top, one pclk domain. */
`timescale 1ns/1ns
module pic_props (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic [3:0]        trap_evt,
  input wire logic              level_ld,
  input wire logic [3:0]        level_in,
  input wire logic              irq_req,
  input wire pic_pkg::pic_pend_s pend,
  input wire logic [23:0]       irq_addr,
  input wire logic              trap_req,
  input wire logic [23:0]       trap_addr,
  input wire logic [3:0]        cpu_level
);
  import pic_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////
  // request side: level compare and table address
  AST_BLOCK: assert property (cpu_level >= 4'h7 |=> !irq_req)
    else $error("request raised at blocking level");
  AST_ABOVE: assert property (irq_req |-> pend.lvl > $past(cpu_level))
    else $error("request not above cpu level");
  AST_VEC: assert property (irq_req |-> pend.vec >= 7'h08 && pend.vec <= 7'h55)
    else $error("user vector out of range");
  AST_ADDR: assert property (irq_req |-> irq_addr[7:0] == {pend.vec, 1'b0} + 8'h04
    && irq_addr[23:9] == 15'h0)
    else $error("vector address wrong");
  AST_HOLD: assert property (!irq_req |-> $stable(pend))
    else $error("pending moved with no source");
  // trap side and core level load
  AST_TRAP: assert property (trap_evt[0] |-> ##2 trap_req && trap_addr[7:0] == 8'h06)
    else $error("oscillator trap not reported");
  AST_TRAP_SET: assert property (trap_req |-> trap_addr[7:0] inside {8'h06, 8'h08,
    8'h0a, 8'h0c})
    else $error("trap address outside trap slots");
  AST_LOAD: assert property (level_ld |=> cpu_level == $past(level_in))
    else $error("cpu level not loaded");
endmodule : pic_props
////////////////////////////////////////////////////////////////////////
bind pic_top pic_props i_pic_props (.pclk(pclk), .presetn(presetn), .trap_evt(trap_evt),
  .level_ld(level_ld), .level_in(level_in), .irq_req(irq_req), .pend(pend),
  .irq_addr(irq_addr), .trap_req(trap_req), .trap_addr(trap_addr), .cpu_level(cpu_level));

// ==== sim/pic_top_tb_top.sv ====
/* pic_top_tb_top: self-checking bench for pic_top.
   Assumes zero-wait APB and the core model as far side. */
`timescale 1ns/1ns
module pic_top_tb_top;
  import pic_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic [117:0] src_pulse = 0;
  logic [2:0] ext_pin = 0;
  logic [3:0] trap_evt = 0, level_in, cpu_level, dly = 0;
  logic level_ld, irq_req, trap_req, go = 0, rerr;
  pic_pend_s pend;
  logic [23:0] irq_addr, trap_addr;
  int taken, errors = 0, compares = 0;
  always #20 pclk = ~pclk;
  pic_top i_pic_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_pulse(src_pulse), .ext_pin(ext_pin), .trap_evt(trap_evt),
    .level_ld(level_ld), .level_in(level_in), .irq_req(irq_req), .pend(pend),
    .irq_addr(irq_addr), .trap_req(trap_req), .trap_addr(trap_addr), .cpu_level(cpu_level));
  pic_core_model i_pic_core_model (.pclk(pclk), .presetn(presetn), .go(go), .dly(dly),
    .irq_req(irq_req), .pend(pend), .level_ld(level_ld), .level_in(level_in), .taken(taken));
  ////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one transfer, held until pready, then an idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      close_out();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rdat, e);
  endtask : rd
  task automatic wait_irq(input logic e);
    for (int n = 0; n < 30 && irq_req !== e; n++) @(posedge pclk);
    chk("irq_req", 32'(irq_req), 32'(e));
    if (irq_req !== e) close_out();
  endtask : wait_irq
  task automatic pulse(input logic [117:0] m);
    src_pulse <= m;
    @(posedge pclk);
    src_pulse <= '0;
    repeat (3) @(posedge pclk);
  endtask : pulse
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(OFF_CTRL1, 32'h0, "ctrl1");
    rd(OFF_PEND, 32'h0, "pend");
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped", 32'(rerr), 32'h1);
    apb(1'b1, OFF_CORE, 32'h8);
    rd(OFF_CORE, 32'h0, "core bit3");
  endtask : t_regs
  // tie at equal priority, then a raised priority, then the alternate table
  task automatic t_arb;
    apb(1'b1, OFF_EN0, 32'h28);
    apb(1'b1, OFF_PRIO0, 32'h0050_5000);
    pulse(118'h28);
    wait_irq(1'b1);
    chk("vec", 32'(pend.vec), 32'd11);
    chk("lvl", 32'(pend.lvl), 32'd5);
    chk("addr", 32'(irq_addr), 32'h1a);
    apb(1'b1, OFF_PRIO0, 32'h0060_5000);
    // pending latch trails the write by one edge
    @(posedge pclk);
    chk("vec", 32'(pend.vec), 32'd13);
    apb(1'b1, OFF_CTRL2, 32'h8000);
    @(posedge pclk);
    chk("alt addr", 32'(irq_addr), 32'h11e);
    rd(OFF_CTRL2, 32'h8000, "ctrl2");
    rd(OFF_FLAG0, 32'h28, "flags kept");
  endtask : t_arb
  task automatic t_level;
    apb(1'b1, OFF_STAT, 32'hc0);
    wait_irq(1'b0);
    chk("level", 32'(cpu_level), 32'h6);
    apb(1'b1, OFF_CTRL1, 32'h8000);
    apb(1'b1, OFF_STAT, 32'h0);
    rd(OFF_STAT, 32'hc0, "locked");
    apb(1'b1, OFF_CTRL1, 32'h0);
    // priority 7 source, so only a level of 7 or more can hold the request down
    apb(1'b1, OFF_PRIO0, 32'h0070_5000);
    apb(1'b1, OFF_STAT, 32'he0);
    repeat (3) @(posedge pclk);
    chk("lvl7", 32'(irq_req), 32'h0);
    apb(1'b1, OFF_STAT, 32'h0);
    wait_irq(1'b1);
  endtask : t_level
  // software clear, reserved request, disabled external pin, core entry
  task automatic t_flags;
    apb(1'b1, OFF_FLAG0, 32'h0);
    wait_irq(1'b0);
    pulse(118'h10);
    rd(OFF_FLAG0, 32'h0, "reserved");
    // pin source gets a real priority so only its enable keeps it quiet
    apb(1'b1, OFF_PRIO0, 32'h0070_5003);
    apb(1'b1, OFF_EN0, 32'h8);
    ext_pin <= 3'b001;
    repeat (5) @(posedge pclk);
    rd(OFF_FLAG0, 32'h1, "ext0");
    chk("ext off", 32'(irq_req), 32'h0);
    go <= 1'b1;
    dly <= 4'h3;
    pulse(118'h8);
    wait_irq(1'b0);
    chk("entry", 32'(cpu_level), 32'h5);
    chk("taken", 32'(taken), 32'h1);
    // falling edge select on pin zero
    apb(1'b1, OFF_FLAG0, 32'h0);
    apb(1'b1, OFF_CTRL2, 32'h8001);
    ext_pin <= 3'b000;
    repeat (5) @(posedge pclk);
    rd(OFF_FLAG0, 32'h1, "ext0 fall");
  endtask : t_flags
  task automatic t_trap;
    trap_evt <= 4'h1;
    @(posedge pclk);
    trap_evt <= 4'h0;
    repeat (3) @(posedge pclk);
    chk("trap", 32'(trap_addr), 32'h106);
    chk("trap req", 32'(trap_req), 32'h1);
    rd(OFF_CTRL1, 32'h2, "trap flag");
  endtask : t_trap
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_regs();
    t_arb();
    t_level();
    t_flags();
    t_trap();
    close_out();
  end
endmodule : pic_top_tb_top
